// file: design/strap_led_pkg.sv
package strap_led_pkg;
	// ==========================================================
	// Pin indices within the multiplexed group
	localparam int pin_count = 5;
	localparam int addr0_index = 0;
	localparam int addr1_index = 1;
	localparam int addr2_index = 2;
	localparam int addr3_index = 3;
	localparam int addr4_index = 4;

	// ==========================================================
	// Reset values
	localparam logic [4:0] addr_reset = 5'h00;
	localparam logic mode_reset = 1'h0;

	// ==========================================================
	// Timing
	localparam int clk_period_ns = 10;
	localparam int collision_hold_ms = 70;
	// Longest time rounds down
	localparam int collision_hold_cycles = (collision_hold_ms * 1000000) / clk_period_ns;

	// ==========================================================
	// Interface modes chosen by the address-1 strap and speed select
	typedef enum logic [1:0] {
		mii_10_type_v,
		mii_100_type_v,
		serial_10_type_v,
		symbol_100_type_v
	} mac_if_mode_type;

	// Pin group: input, output, output enable (low = driving)
	typedef struct packed {
		logic [4:0] level_in;
		logic [4:0] level_out;
		logic [4:0] oe_low;
	} pin_group_type;

	// Status indications feeding the LEDs; bits 1 to 4 in pin order, bit 0 (activity) drives no pin
	typedef struct packed {
		logic rx_activity;
		logic tx_activity;
		logic link_valid;
		logic collision;
		logic activity;
	} led_status_type;

	// Configuration caught from the straps
	typedef struct packed {
		logic [4:0] phy_address;
		logic stream_select;
		mac_if_mode_type mac_mode;
	} strap_config_type;
endpackage

// file: design/pulse_stretch.sv
module pulse_stretch #(
	parameter int hold_cycles = 7000000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic trigger,
	output logic stretched
);
	// ==========================================================
	// Retriggerable hold counter
	logic [31:0] remaining;

	// Reloads on every trigger so a burst keeps the LED lit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remaining <= 32'h0;
		end else if (trigger) begin
			remaining <= 32'(hold_cycles);
		end else if (remaining != 32'h0) begin
			remaining <= remaining - 32'h1;
		end
	end

	assign stretched = (remaining != 32'h0);
endmodule

// file: design/strap_sample_led_pins.sv
module strap_sample_led_pins #(
	parameter int collision_hold = strap_led_pkg::collision_hold_cycles
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hard_reset_low,
	input wire logic soft_reset,
	input wire logic config_priority_select,
	input wire logic speed_select_pin,
	input wire logic force_leds_on,
	input wire strap_led_pkg::led_status_type status,
	input wire logic [4:0] pin_in,
	output logic [4:0] pin_out,
	output logic [4:0] pin_oe_low,
	output strap_led_pkg::strap_config_type config_out,
	output logic sampling_done,
	output logic priority_software
);
	// ==========================================================
	// Phase tracking
	typedef enum logic [1:0] {
		in_reset_type_v,
		sampling_type_v,
		running_type_v
	} phase_type;

	phase_type phase;
	phase_type next_phase;
	logic [4:0] strap;
	logic strap_priority;
	logic collision_led;
	logic [4:0] indication;

	function automatic strap_led_pkg::mac_if_mode_type decode_mode(input logic stream,
			input logic speed);
		unique case ({stream, speed})
			2'b00: decode_mode = strap_led_pkg::mii_10_type_v;
			2'b01: decode_mode = strap_led_pkg::mii_100_type_v;
			2'b10: decode_mode = strap_led_pkg::serial_10_type_v;
			default: decode_mode = strap_led_pkg::symbol_100_type_v;
		endcase
	endfunction

	// Hard reset holds inputs; release moves to one sampling cycle
	always_comb begin
		next_phase = phase;
		unique case (phase)
			in_reset_type_v: begin
			end
			default: begin
			end
		endcase
		if (!hard_reset_low) begin
			next_phase = in_reset_type_v;
		end else if (phase == in_reset_type_v) begin
			next_phase = sampling_type_v;
		end else begin
			next_phase = running_type_v;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= in_reset_type_v;
		end else begin
			phase <= next_phase;
		end
	end

	// ==========================================================
	// Strap capture
	// Clocked capture at reset exit; soft reset does not enter this capture logic, so it cannot resample
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap <= strap_led_pkg::addr_reset;
			strap_priority <= strap_led_pkg::mode_reset;
		end else if (phase == in_reset_type_v && hard_reset_low) begin
			strap <= pin_in;
			strap_priority <= config_priority_select;
		end
	end

	// Address straight from the straps, mode from address-1 plus speed select
	always_comb begin
		config_out.phy_address = strap;
		config_out.stream_select = strap[strap_led_pkg::addr1_index];
		config_out.mac_mode = decode_mode(strap[strap_led_pkg::addr1_index],
			speed_select_pin);
	end

	assign sampling_done = (phase == running_type_v);
	assign priority_software = strap_priority;

	// ==========================================================
	// LED drive
	pulse_stretch #(
		.hold_cycles(collision_hold)
	) collision_stretch (
		.clk(clk),
		.rst(rst),
		.trigger(status.collision),
		.stretched(collision_led)
	);

	// Indications per pin; force-on overrides for diagnostics
	always_comb begin
		indication[strap_led_pkg::addr0_index] = status.link_valid;
		indication[strap_led_pkg::addr1_index] = collision_led;
		indication[strap_led_pkg::addr2_index] = status.link_valid;
		indication[strap_led_pkg::addr3_index] = status.tx_activity;
		indication[strap_led_pkg::addr4_index] = status.rx_activity;
		if (force_leds_on) begin
			indication = 5'h1f;
		end
	end

	// Output data registered; inverted against the strap so the LED lights
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out <= 5'h00;
		end else begin
			pin_out <= indication ^ strap;
		end
	end

	// Turn-around: inputs until sampled, outputs after, soft reset ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_oe_low <= 5'h1f;
		end else if (next_phase == running_type_v) begin
			pin_oe_low <= 5'h00;
		end else begin
			pin_oe_low <= 5'h1f;
		end
	end

	// ==========================================================
	// Checks
	sequence s_release;
		$rose(hard_reset_low);
	endsequence

	sequence s_drive_on;
		##1 pin_oe_low == 5'h1f ##1 pin_oe_low == 5'h00;
	endsequence

	a_inputs_in_reset: assert property (@(posedge clk) disable iff (rst)
		!hard_reset_low |=> pin_oe_low == 5'h1f)
		else $error("pins driven during hard reset");

	a_release_turnaround: assert property (@(posedge clk) disable iff (rst)
		s_release |-> s_drive_on)
		else $error("pins did not turn to outputs after sampling");

	a_soft_reset_hold: assert property (@(posedge clk) disable iff (rst)
		(soft_reset && sampling_done && hard_reset_low) |=> (pin_oe_low == 5'h00
		&& $stable(strap)))
		else $error("soft reset disturbed pins");

	a_output_polarity: assert property (@(posedge clk) disable iff (rst)
		sampling_done && !force_leds_on |=> pin_out[2] == ($past(status.link_valid)
		^ strap[2]))
		else $error("output polarity wrong");

	a_addr0_capture: assert property (@(posedge clk) disable iff (rst)
		s_release |=> config_out.phy_address[0] == $past(pin_in[0]))
		else $error("address bit 0 not captured");

	a_link_on_addr0: assert property (@(posedge clk) disable iff (rst)
		sampling_done && !force_leds_on |=> pin_out[0] == ($past(status.link_valid)
		^ strap[0]))
		else $error("address-0 pin not showing link");

	a_mode_select: assert property (@(posedge clk) disable iff (rst)
		config_out.stream_select == strap[1] && (strap[1] == 1'b0) ==
		(config_out.mac_mode inside {strap_led_pkg::mii_10_type_v,
		strap_led_pkg::mii_100_type_v}))
		else $error("interface mode wrong");

	a_collision_hold: assert property (@(posedge clk) disable iff (rst)
		status.collision |=> collision_led [*8])
		else $error("collision LED not held");

	a_address_stable: assert property (@(posedge clk) disable iff (rst)
		sampling_done && hard_reset_low |=> $stable(config_out.phy_address))
		else $error("address changed outside hard reset");

	// Remaining pins follow the same inverted sense as the link pin
	a_tx_rx_polarity: assert property (@(posedge clk) disable iff (rst)
		sampling_done && !force_leds_on |=> pin_out[4:3] ==
		({$past(status.rx_activity), $past(status.tx_activity)} ^ strap[4:3]))
		else $error("tx or rx pin polarity wrong");

	a_force_all_on: assert property (@(posedge clk) disable iff (rst)
		sampling_done && force_leds_on |=> pin_out == ~strap)
		else $error("forced LEDs not all asserted");

	a_collision_pin: assert property (@(posedge clk) disable iff (rst)
		sampling_done && !force_leds_on |=> pin_out[1] == ($past(collision_led)
		^ strap[1]))
		else $error("collision pin not showing stretched collision");

	a_all_straps_caught: assert property (@(posedge clk) disable iff (rst)
		s_release |=> config_out.phy_address == $past(pin_in))
		else $error("address straps not captured");

	a_addr2_capture: assert property (@(posedge clk) disable iff (rst)
		s_release |=> config_out.phy_address[2] == $past(pin_in[2]))
		else $error("address bit 2 not captured");

	a_priority_capture: assert property (@(posedge clk) disable iff (rst)
		s_release |=> priority_software == $past(config_priority_select))
		else $error("priority strap not captured");

	// Done and drive change on the same edge, so they never disagree
	a_done_with_drive: assert property (@(posedge clk) disable iff (rst)
		sampling_done == (pin_oe_low == 5'h00))
		else $error("drive state and sampling done disagree");
endmodule

// file: testbench/board_model.sv
// ==========================================================
// Board side: pull resistors, with LEDs in series
module board_model (
	input wire logic [4:0] pulls,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe_low,
	output logic [4:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Each pin has a resistor, so a released pin sits at the pull level, never floating
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pin_in[i] = pin_oe_low[i] ? pulls[i] : pin_out[i];
		end
	end
endmodule

// file: testbench/strap_sample_led_pins_bench.sv
module strap_sample_led_pins_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals
	localparam int hold = 20;
	logic clk, rst, hard_reset_low, soft_reset, prio, speed, force_on, done, prio_sw;
	strap_led_pkg::led_status_type status;
	strap_led_pkg::strap_config_type cfg;
	logic [4:0] pulls, pin_in, pin_out, oe_low;
	int bad_count, n_tests, seed, cycles;
	// ==========================================================
	// Design and board
	strap_sample_led_pins #(.collision_hold(hold)) i_dut (.clk(clk), .rst(rst),
		.hard_reset_low(hard_reset_low), .soft_reset(soft_reset),
		.config_priority_select(prio), .speed_select_pin(speed), .force_leds_on(force_on),
		.status(status), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_low(oe_low),
		.config_out(cfg), .sampling_done(done), .priority_software(prio_sw));
	board_model i_board (.pulls(pulls), .pin_out(pin_out), .pin_oe_low(oe_low),
		.pin_in(pin_in));
	// ==========================================================
	// Helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("n_tests=%0d bad_count=%0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Asserted level is the inverse of the strap, so drive = indication xor strap
	function automatic logic [4:0] led_exp(input strap_led_pkg::led_status_type s,
		input logic [4:0] strap, input logic frc);
		logic [4:0] ind;
		ind = {s.rx_activity, s.tx_activity, s.link_valid, s.collision, s.link_valid};
		if (frc) begin
			ind = 5'h1f;
		end
		return ind ^ strap;
	endfunction
	// Hard reset with given straps, then checks of the caught configuration
	task automatic hard_reset(input logic [4:0] p, input logic sp, input logic pr);
		@(negedge clk);
		hard_reset_low = 1'h0;
		pulls = p;
		speed = sp;
		prio = pr;
		repeat (3) @(negedge clk);
		check(oe_low, 5'h1f);
		hard_reset_low = 1'h1;
		@(negedge clk);
		check(cfg.phy_address, p);
		check(cfg.stream_select, p[1]);
		check(cfg.mac_mode, {p[1], sp});
		check(prio_sw, pr);
		@(negedge clk);
		check({done, oe_low}, 6'h20);
	endtask
	// ==========================================================
	// Clock and hang guard; a few hundred cycles expected
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			results();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		logic [4:0] p;
		logic [31:0] r;
		seed = 32'hb247;
		{rst, hard_reset_low, soft_reset, prio, speed, force_on} = 6'h20;
		status = '0;
		pulls = 5'h00;
		repeat (10) @(negedge clk);
		rst = 1'h0;
		// One pass per interface mode, random straps and traffic each time
		for (int m = 0; m < 4; m++) begin
			r = $random(seed);
			p = r[4:0];
			p[1] = m[1];
			hard_reset(p, m[0], r[8]);
			repeat (40) begin
				r = $random(seed);
				status = r[4:0];
				status.collision = 1'h0;
				r = $random(seed);
				force_on = (r[2:0] == 3'h0);
				soft_reset = r[3];
				@(negedge clk);
				check(pin_out, led_exp(status, p, force_on));
				check({oe_low, cfg.phy_address}, {5'h00, p});
			end
			$display("test mode %0d done", m);
		end
		// One collision pulse must hold the indication for the stretch time
		{soft_reset, force_on} = 2'h0;
		status = '0;
		status.collision = 1'h1;
		@(negedge clk);
		status.collision = 1'h0;
		repeat (2) @(negedge clk);
		check(pin_out[1], {~p[1]});
		repeat (hold - 2) @(negedge clk);
		check(pin_out[1], {~p[1]});
		@(negedge clk);
		check(pin_out[1], p[1]);
		$display("test collision done");
		results();
	end
endmodule
